// ---- hw/spread_defines.vh ----
// Register offsets, field positions and reset values of the spread spectrum divider.
// Included by the modulator and its ramp generator; definitions only.
`ifndef SPREAD_DEFINES_VH
`define SPREAD_DEFINES_VH

// Register offsets (8-bit register port)
`define ADDR_SPREAD_ENABLE_PERIOD_HIGH 8'h10
`define ADDR_SPREAD_PERIOD_LOW         8'h11
`define ADDR_DIVIDER_INTEGER_PART      8'h12
`define ADDR_DIVIDER_FRACTION_HIGH     8'h13
`define ADDR_DIVIDER_FRACTION_LOW      8'h14
`define ADDR_SPREAD_STEP_HIGH          8'h15
`define ADDR_SPREAD_STEP_LOW           8'h16
`define ADDR_DIVIDER_CONTROL           8'h18
`define ADDR_ATTENUATOR_CONFIG         8'h24

// Field positions
`define BIT_SPREAD_ENABLE      7
`define BIT_DIVIDER_HOLD_N     7
`define BIT_DIVIDER_INT_MODE   1
`define BIT_DIVIDER_ENABLE     0
`define BIT_ATTEN_ENABLE       2

// Reset values
`define RST_REG8               8'h00
`define RST_DIVIDER_CONTROL    8'h00

// Writable bits per register; reserved bits are never stored
`define MASK_SPREAD_ENABLE_PERIOD_HIGH 8'h8F
`define MASK_DIVIDER_CONTROL           8'h83
`define MASK_ATTENUATOR_CONFIG         8'h07
`define MASK_FULL_BYTE                 8'hFF

// Attenuator multiplier codes
`define ATTEN_QUARTER          2'h0
`define ATTEN_UNITY            2'h1
`define ATTEN_FIVE_QUARTERS    2'h2
`define ATTEN_DOUBLE           2'h3

// Fixed-point widths: divider value is 8.24, fraction input 16 bits
`define STEP_FRAC_BITS         24
`define DIV_FRAC_BITS          16
`define DIV_VALUE_W            32

`endif

// ---- hw/spread_ramp.v ----
// Triangle ramp generator: accumulates the step below the programmed divider value.
// Assumes i_tick pulses once per divider output cycle and i_run holds it idle when low.
`timescale 1ns/100ps
`default_nettype none
`include "spread_defines.vh"

module spread_ramp #(
  parameter PERIOD_W = 12,
  parameter STEP_W   = 16,
  parameter OFS_W    = 32
)(
  // Clock and reset
  input  wire                i_clk,
  input  wire                i_rst_b,
  // Control
  input  wire                i_run,
  input  wire                i_tick,
  input  wire [PERIOD_W-1:0] i_period,
  input  wire [STEP_W-1:0]   i_step,
  // Status
  output reg  [OFS_W-1:0]    o_offset,
  output reg                 o_falling
);

  reg  [PERIOD_W:0]   step_count;
  wire [PERIOD_W:0]   next_count = step_count + {{PERIOD_W{1'b0}}, 1'b1};
  wire [PERIOD_W:0]   leg_ticks  = {i_period, 1'b0};
  wire [OFS_W-1:0]    step_wide = {{(OFS_W-STEP_W){1'b0}}, i_step};

  // Offset grows while the value falls, shrinks back to zero on the rise
  always @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      o_offset   <= {OFS_W{1'b0}};
      o_falling  <= 1'b1;
      step_count <= {(PERIOD_W+1){1'b0}};
    end
    else if (!i_run)
    begin
      o_offset   <= {OFS_W{1'b0}};
      o_falling  <= 1'b1;
      step_count <= {(PERIOD_W+1){1'b0}};
    end
    else if (i_tick)
    begin
      // A leg lasts twice the period count, so the count is a quarter cycle
      if (next_count >= leg_ticks)
      begin
        step_count <= {(PERIOD_W+1){1'b0}};
        o_falling  <= ~o_falling;
      end
      else
        step_count <= next_count;
      if (o_falling)
        o_offset <= o_offset + step_wide;
      else if (o_offset > step_wide)
        o_offset <= o_offset - step_wide;
      else
        o_offset <= {OFS_W{1'b0}};                         // clamp at top
    end
  end

endmodule // spread_ramp
`default_nettype wire

// ---- hw/spread_frac_divider.v ----
// Spread spectrum modulator and register file of the fractional output divider.
// Assumes a synchronous 8-bit register write/read port driven by the serial bus logic.
`timescale 1ns/100ps
`default_nettype none
`include "spread_defines.vh"

module spread_frac_divider #(
  parameter PERIOD_W = 12,
  parameter STEP_W   = 16
)(
  // Clock and reset
  input  wire        i_clk,
  input  wire        i_rst_b,
  // Register port
  input  wire        i_reg_wr,
  input  wire [7:0]  i_reg_addr,
  input  wire [7:0]  i_reg_wdata,
  output reg  [7:0]  o_reg_rdata,
  // Divider output cycle from the analog divider
  input  wire        i_div_tick,
  // Divider control
  output wire [31:0] o_frac_out_divider,
  output wire        o_divider_hold_n,
  output wire        o_divider_enable,
  output wire        o_divider_int_mode,
  // Jitter attenuator and spread status
  output wire        o_atten_enable,
  output wire [1:0]  o_attenuator_mult_sel,
  output wire [3:0]  o_atten_mult_q2,
  output wire        o_spread_active,
  output wire        o_ramp_falling
);

  // Register slots, one per mapped address
  localparam N_REGS         = 9;
  localparam IDX_EN_PERIOD  = 0;
  localparam IDX_PERIOD_LOW = 1;
  localparam IDX_INT_PART   = 2;
  localparam IDX_FRAC_HIGH  = 3;
  localparam IDX_FRAC_LOW   = 4;
  localparam IDX_STEP_HIGH  = 5;
  localparam IDX_STEP_LOW   = 6;
  localparam IDX_CONTROL    = 7;
  localparam IDX_ATTEN      = 8;

  // Configuration registers
  reg [7:0] cfg [0:N_REGS-1];
  integer   w;
  integer   r;

  wire [31:0] ramp_offset;
  wire        ramp_falling;

  // Multiplier in quarters, drives the o_atten_mult_q2 status output only
  function [3:0] mult_quarters;
    input [1:0] code;
    begin
      case (code)
        `ATTEN_QUARTER:       mult_quarters = 4'h1;
        `ATTEN_UNITY:         mult_quarters = 4'h4;
        `ATTEN_FIVE_QUARTERS: mult_quarters = 4'h5;
        `ATTEN_DOUBLE:        mult_quarters = 4'h8;
        default:              mult_quarters = 4'h4;
      endcase
    end
  endfunction

  // Address decode shared by writes and readback, one-hot per slot
  function [N_REGS-1:0] reg_select;
    input [7:0] addr;
    begin
      reg_select = {N_REGS{1'b0}};
      case (addr)
        `ADDR_SPREAD_ENABLE_PERIOD_HIGH: reg_select[IDX_EN_PERIOD]  = 1'b1;
        `ADDR_SPREAD_PERIOD_LOW:         reg_select[IDX_PERIOD_LOW] = 1'b1;
        `ADDR_DIVIDER_INTEGER_PART:      reg_select[IDX_INT_PART]   = 1'b1;
        `ADDR_DIVIDER_FRACTION_HIGH:     reg_select[IDX_FRAC_HIGH]  = 1'b1;
        `ADDR_DIVIDER_FRACTION_LOW:      reg_select[IDX_FRAC_LOW]   = 1'b1;
        `ADDR_SPREAD_STEP_HIGH:          reg_select[IDX_STEP_HIGH]  = 1'b1;
        `ADDR_SPREAD_STEP_LOW:           reg_select[IDX_STEP_LOW]   = 1'b1;
        `ADDR_DIVIDER_CONTROL:           reg_select[IDX_CONTROL]    = 1'b1;
        `ADDR_ATTENUATOR_CONFIG:         reg_select[IDX_ATTEN]      = 1'b1;
        default:                         reg_select = {N_REGS{1'b0}};
      endcase
    end
  endfunction

  // Writable bits per slot; reserved bits read back as zero
  function [7:0] reg_mask;
    input integer idx;
    begin
      case (idx)
        IDX_EN_PERIOD: reg_mask = `MASK_SPREAD_ENABLE_PERIOD_HIGH;
        IDX_CONTROL:   reg_mask = `MASK_DIVIDER_CONTROL;
        IDX_ATTEN:     reg_mask = `MASK_ATTENUATOR_CONFIG;
        default:       reg_mask = `MASK_FULL_BYTE;
      endcase
    end
  endfunction

  // Reset value per slot
  function [7:0] reg_reset;
    input integer idx;
    begin
      case (idx)
        IDX_CONTROL: reg_reset = `RST_DIVIDER_CONTROL;
        default:     reg_reset = `RST_REG8;
      endcase
    end
  endfunction

  wire [N_REGS-1:0] addr_sel = reg_select(i_reg_addr);

  // Register writes; unmapped addresses select no slot and are dropped
  always @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      for (w = 0; w < N_REGS; w = w + 1)
        cfg[w] <= reg_reset(w);
    end
    else if (i_reg_wr)
    begin
      for (w = 0; w < N_REGS; w = w + 1)
        if (addr_sel[w])
          cfg[w] <= i_reg_wdata & reg_mask(w);
    end
  end

  // Readback, unmapped addresses read zero
  always @*
  begin
    o_reg_rdata = 8'h00;
    for (r = 0; r < N_REGS; r = r + 1)
      o_reg_rdata = o_reg_rdata | (cfg[r] & {8{addr_sel[r]}});
  end

  // Field assembly
  wire                spread_en  = cfg[IDX_EN_PERIOD][`BIT_SPREAD_ENABLE];
  wire [PERIOD_W-1:0] period     = {cfg[IDX_EN_PERIOD][3:0],
                                    cfg[IDX_PERIOD_LOW]};
  wire [STEP_W-1:0]   step       = {cfg[IDX_STEP_HIGH], cfg[IDX_STEP_LOW]};
  // Programmed value in 8.24 fixed point
  wire [31:0]         prog_value = {cfg[IDX_INT_PART], cfg[IDX_FRAC_HIGH],
                                    cfg[IDX_FRAC_LOW], 8'h00};

  assign o_divider_hold_n   = cfg[IDX_CONTROL][`BIT_DIVIDER_HOLD_N];
  assign o_divider_enable   = cfg[IDX_CONTROL][`BIT_DIVIDER_ENABLE];
  assign o_divider_int_mode = cfg[IDX_CONTROL][`BIT_DIVIDER_INT_MODE];

  // Ramp runs only with spread on and divider released; hold restarts it
  wire run = spread_en & o_divider_hold_n & o_divider_enable;

  spread_ramp #(
    .PERIOD_W (PERIOD_W),
    .STEP_W   (STEP_W),
    .OFS_W    (32)       // 8.24 offset spans any supported spread
  ) u_ramp (
    .i_clk     (i_clk),
    .i_rst_b   (i_rst_b),
    .i_run     (run),
    .i_tick    (i_div_tick),
    .i_period  (period),
    .i_step    (step),
    .o_offset  (ramp_offset),
    .o_falling (ramp_falling)
  );

  // Saturate at zero so a huge step cannot wrap above the programmed value
  wire [31:0] mod_value = (ramp_offset > prog_value) ? 32'h00000000
                                                     : prog_value - ramp_offset;

  // Spread only touches this fractional divider; integer dividers lie elsewhere
  assign o_frac_out_divider    = run ? mod_value : prog_value;
  assign o_atten_enable        = spread_en | cfg[IDX_ATTEN][`BIT_ATTEN_ENABLE];
  assign o_attenuator_mult_sel = cfg[IDX_ATTEN][1:0];
  assign o_atten_mult_q2       = mult_quarters(cfg[IDX_ATTEN][1:0]);
  assign o_spread_active       = run;
  assign o_ramp_falling        = ramp_falling & run;

endmodule // spread_frac_divider
`default_nettype wire

// ---- sim/spread_chk.sv ----
// Port checker for the spread spectrum divider.
// Bound to spread_frac_divider; sees its ports only.
`timescale 1ns/100ps
`default_nettype none
module spread_chk (
  // Clock and reset
  input wire logic        i_clk,
  input wire logic        i_rst_b,
  // Register port
  input wire logic        i_reg_wr,
  input wire logic [7:0]  i_reg_addr,
  input wire logic [7:0]  i_reg_wdata,
  input wire logic [7:0]  o_reg_rdata,
  input wire logic        i_div_tick,
  // Divider and attenuator
  input wire logic [31:0] o_frac_out_divider,
  input wire logic        o_divider_hold_n,
  input wire logic        o_divider_enable,
  input wire logic        o_atten_enable,
  input wire logic [1:0]  o_attenuator_mult_sel,
  input wire logic [3:0]  o_atten_mult_q2,
  input wire logic        o_spread_active,
  input wire logic        o_ramp_falling
);
  logic [31:0] prog;
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);
  // Shadow of the programmed value, the ceiling of every ramp
  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
      prog <= 32'h0;
    else if (i_reg_wr && i_reg_addr == 8'h12)
      prog[31:24] <= i_reg_wdata;
    else if (i_reg_wr && i_reg_addr == 8'h13)
      prog[23:16] <= i_reg_wdata;
    else if (i_reg_wr && i_reg_addr == 8'h14)
      prog[15:8] <= i_reg_wdata;
  end
  // Write then read of the same place; a tick while running
  sequence s_wr12; i_reg_wr && i_reg_addr == 8'h12 ##1 i_reg_addr == 8'h12; endsequence
  sequence s_tick; i_div_tick && o_spread_active && !i_reg_wr; endsequence
  property p_rd12; s_wr12 |-> o_reg_rdata == $past(i_reg_wdata); endproperty
  a_rd12: assert property (p_rd12) else $error("readback wrong");
  property p_aen; o_spread_active |-> o_atten_enable; endproperty
  a_aen: assert property (p_aen) else $error("attenuator off");
  property p_mult; o_atten_mult_q2 == (o_attenuator_mult_sel == 2'h3 ? 4'h8 :
    o_attenuator_mult_sel == 2'h2 ? 4'h5 : o_attenuator_mult_sel == 2'h1 ? 4'h4 : 4'h1);
  endproperty
  a_mult: assert property (p_mult) else $error("multiplier wrong");
  property p_idle; !o_spread_active && $past(!o_spread_active) |-> o_frac_out_divider == prog;
  endproperty
  a_idle: assert property (p_idle) else $error("idle value moved");
  property p_cap; o_frac_out_divider <= prog; endproperty
  a_cap: assert property (p_cap) else $error("value above program");
  property p_hold; o_spread_active |-> o_divider_hold_n && o_divider_enable; endproperty
  a_hold: assert property (p_hold) else $error("active in hold");
  property p_still; $past(o_spread_active) && !$past(i_div_tick) && !$past(i_reg_wr)
    |-> $stable(o_frac_out_divider); endproperty
  a_still: assert property (p_still) else $error("moved without tick");
  property p_fall; s_tick ##0 o_ramp_falling |=> o_frac_out_divider <= $past(o_frac_out_divider);
  endproperty
  a_fall: assert property (p_fall) else $error("falling leg rose");
  property p_rise; s_tick ##0 !o_ramp_falling |=> o_frac_out_divider >= $past(o_frac_out_divider);
  endproperty
  a_rise: assert property (p_rise) else $error("rising leg fell");
endmodule // spread_chk
bind spread_frac_divider spread_chk u_chk (.*);
`default_nettype wire

// ---- sim/spread_host.sv ----
// Host model: writes registers and paces divider ticks.
// Drives on the falling clock edge; address held after a write.
`timescale 1ns/100ps
`default_nettype none
module spread_host (
  input  wire logic       i_clk,
  output var  logic       o_wr,
  output var  logic [7:0] o_addr,
  output var  logic [7:0] o_data,
  output var  logic       o_tick
);
  initial {o_wr, o_addr, o_data, o_tick} = 18'h0;
  // Caller passes values already raised to the bottom and rate-matched
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge i_clk);
    {o_wr, o_addr, o_data} = {1'b1, a, d};
    @(negedge i_clk);
    o_wr = 1'b0;
  endtask
  // Hold low then release to restart the ramp
  task automatic restart;
    wr(8'h18, 8'h01);
    wr(8'h18, 8'h81);
  endtask
  // One divider output cycle
  task automatic tick;
    @(negedge i_clk);
    o_tick = 1'b1;
    @(negedge i_clk);
    o_tick = 1'b0;
  endtask
endmodule // spread_host
`default_nettype wire

// ---- sim/spread_frac_divider_tb.sv ----
// Self-checking bench for the spread spectrum divider.
// Host model drives the register port; checker is bound.
`timescale 1ns/100ps
`default_nettype none
module spread_frac_divider_tb;
  logic        clk = 1'b0;
  logic        rst_b = 1'b0;
  logic        wr, tick, hold_n, aen, act, fall, en, imode;
  logic [3:0]  q_exp [0:3] = '{4'h1, 4'h4, 4'h5, 4'h8};
  logic [7:0]  addr, wdata, rdata;
  logic [31:0] div;
  logic [1:0]  sel;
  logic [3:0]  q2;
  int          mismatches = 0;
  int          n_checks = 0;
  // Rows: address, data written, data read back
  logic [23:0] rows [0:10] = '{24'h10FF8F, 24'h11A5A5, 24'h120C0C, 24'h139090,
    24'h140000, 24'h150202, 24'h169898, 24'h18FF83, 24'h24FF07, 24'h305500, 24'h180000};
  logic [7:0]  offs [0:4] = '{8'h10, 8'h20, 8'h30, 8'h40, 8'h30};
  logic [4:0]  falls = 5'b11100;
  spread_host host (.i_clk(clk), .o_wr(wr), .o_addr(addr), .o_data(wdata), .o_tick(tick));
  spread_frac_divider dut (.i_clk(clk), .i_rst_b(rst_b), .i_reg_wr(wr), .i_reg_addr(addr),
    .i_reg_wdata(wdata), .o_reg_rdata(rdata), .i_div_tick(tick), .o_frac_out_divider(div),
    .o_divider_hold_n(hold_n), .o_divider_enable(en), .o_divider_int_mode(imode),
    .o_atten_enable(aen), .o_attenuator_mult_sel(sel), .o_atten_mult_q2(q2),
    .o_spread_active(act), .o_ramp_falling(fall));
  always #25 clk = ~clk;
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic stop_test;
    if (mismatches == 0 && n_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // Hang guard
  initial
  begin
    repeat (3000) @(posedge clk);
    mismatches++;
    stop_test;
  end
  initial
  begin
    repeat (4) @(negedge clk);
    rst_b = 1'b1;
    chk({rdata, q2, div}, 44'h00100000000);
    chk({hold_n, en, imode, act, aen, fall, sel}, 8'h00);
    // Register rows; reserved bits and unmapped place read zero
    for (int i = 0; i < 11; i++)
    begin
      host.wr(rows[i][23:16], rows[i][15:8]);
      chk(rdata, rows[i][7:0]);
    end
    chk(div, 32'h0C900000);
    // Spread off and attenuator bit clear, so only the code shows
    host.wr(8'h10, 8'h00);
    for (int c = 0; c < 4; c++)
    begin
      host.wr(8'h24, c[7:0]);
      chk({aen, sel, q2}, {1'b0, c[1:0], q_exp[c]});
    end
    host.wr(8'h10, 8'h80);
    host.wr(8'h18, 8'h83);
    chk({act, aen, hold_n, en, imode}, 5'b11111);
    host.wr(8'h11, 8'h02);
    host.wr(8'h16, 8'h10);
    host.wr(8'h15, 8'h00);
    host.restart;
    // Period of two: four ticks a leg, step of 16
    for (int i = 0; i < 5; i++)
    begin
      host.tick;
      chk({fall, div}, {falls[4-i], 32'h0C900000 - {24'h0, offs[i]}});
    end
    repeat (3) @(negedge clk);
    chk(div, 32'h0C8FFFD0);
    host.wr(8'h10, 8'h01);
    host.tick;
    chk({act, div}, 33'h00C900000);
    host.wr(8'h10, 8'h80);
    host.wr(8'h18, 8'h01);
    host.tick;
    chk({act, hold_n}, 2'b00);
    host.wr(8'h18, 8'h81);
    host.tick;
    chk(div, 32'h0C8FFFF0);
    stop_test;
  end
endmodule // spread_frac_divider_tb
`default_nettype wire
